/* File: verilog/can_front_pkg.sv */
/*
  can_front_pkg: shared constants of the control, command and status front end.
  Assumes byte-wide host access with a five-bit address.
*/
package can_front_pkg;
  // host address map
  localparam logic [4:0] ADDR_CONTROL = 5'h00;
  localparam logic [4:0] ADDR_COMMAND = 5'h01;
  localparam logic [4:0] ADDR_STATUS = 5'h02;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;

  // control byte fields
  localparam int CTL_TEST_MODE = 7;
  localparam int CTL_SYNC = 6;
  localparam int CTL_OVR_IE = 4;
  localparam int CTL_ERR_IE = 3;
  localparam int CTL_SEND_IE = 2;
  localparam int CTL_RECV_IE = 1;
  localparam int CTL_SOFT_RST = 0;
  localparam logic [7:0] CTL_WRITABLE = 8'hDF;  // bit 5 reserved, reads zero
  localparam logic [7:0] CTL_RESET_VAL = 8'h01;  // soft reset request set at power-up

  // command byte fields
  localparam int CMD_SLEEP = 4;
  localparam int CMD_OVR_CLEAR = 3;
  localparam int CMD_RX_RELEASE = 2;
  localparam int CMD_ABORT = 1;
  localparam int CMD_SEND = 0;
  localparam logic [7:0] CMD_READ_VAL = 8'hFF;

  // status byte fields
  localparam int ST_BUS_OFF = 7;
  localparam int ST_ERR_WARN = 6;
  localparam int ST_TX_ACT = 5;
  localparam int ST_RX_ACT = 4;
  localparam int ST_SEND_DONE = 3;
  localparam int ST_TXBUF_FREE = 2;
  localparam int ST_OVERRUN = 1;
  localparam int ST_RXBUF_FULL = 0;

  // unmapped reads
  localparam logic [7:0] READ_NONE = 8'h00;

  // receive buffers and sleep timing
  localparam int RX_BUFFERS = 2;
  localparam int CNT_W = 2;
  localparam int SLEEP_CLKOUT_BITS = 15;  // bit times of clock output after sleep
  localparam int SLEEP_CNT_W = 4;

  // power state
  typedef enum logic [1:0] {
    PWR_AWAKE,
    PWR_WIND_DOWN,
    PWR_ASLEEP
  } pwr_state_t;
endpackage

/* File: verilog/rx_buf_track.sv */
/*
  rx_buf_track: occupancy of the two receive buffers, full flag and overrun detect.
  Assumes the receive engine pulses store_first before and store_done after a message.
*/
`timescale 1ns/1ps
module rx_buf_track (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // engine side
  input wire logic store_first,
  input wire logic store_done,
  // host side
  input wire logic release_pulse,
  input wire logic flush,
  // results
  output logic full_flag,
  output logic overrun_pulse,
  output logic drop_flag
);
  import can_front_pkg::*;

  logic [CNT_W-1:0] count_ff;  // messages held, 0 to 2
  logic drop_ff;  // current message is being discarded
  logic full_now;

  assign full_now = (count_ff == CNT_W'(RX_BUFFERS));
  // overrun fires on the first byte of a message with no room
  assign overrun_pulse = store_first && full_now && !flush;
  assign full_flag = (count_ff != '0);
  assign drop_flag = drop_ff;

  // drop marker spans one whole message so its tail does not count
  always_ff @(posedge clk) begin
    if (sys_rst || flush) begin
      drop_ff <= 1'b0;
    end else if (store_first) begin
      drop_ff <= full_now;
    end else if (store_done) begin
      drop_ff <= 1'b0;
    end
  end

  // occupancy: store adds, release frees the presented one
  always_ff @(posedge clk) begin
    if (sys_rst || flush) begin
      count_ff <= '0;
    end else begin
      unique case ({store_done && !drop_ff, release_pulse && count_ff != '0})
        2'b10: count_ff <= count_ff + CNT_W'(1);
        2'b01: count_ff <= count_ff - CNT_W'(1);
        default: count_ff <= count_ff;  // none, or both cancel out
      endcase
    end
  end
endmodule

/* File: verilog/can_ctrl_front.sv */
/*
  can_ctrl_front: control, command and status bytes of a stand-alone CAN controller,
  with soft reset, send/abort, receive release, overrun and sleep/wake handling.
  Assumes a synchronous byte-wide host port and a protocol engine that reports
  frame starts, completions, receive stores, bus activity and bit ticks.
*/
`timescale 1ns/1ps
module can_ctrl_front (
  // clock and power-up reset
  input wire logic clk,
  input wire logic sys_rst,
  // host byte port
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [can_front_pkg::ADDR_W-1:0] host_addr,
  input wire logic [can_front_pkg::DATA_W-1:0] host_wdata,
  output logic [can_front_pkg::DATA_W-1:0] host_rdata,
  // transmit engine
  input wire logic tx_start,
  input wire logic tx_done_ok,
  input wire logic tx_active,
  output logic send_pending,
  output logic abort_pulse,
  // receive engine
  input wire logic rx_active,
  input wire logic rx_store_first,
  input wire logic rx_store_done,
  output logic rx_enable,
  output logic rx_drop,
  output logic rx_release,
  // error state from confinement logic
  input wire logic bus_off_in,
  input wire logic error_warn_in,
  // bus observation and bit timing
  input wire logic bus_activity,
  input wire logic bus_free,
  input wire logic bit_tick,
  // interrupt pin level and wake flag
  input wire logic int_n,
  input wire logic wake_flag_clear,
  output logic wake_irq_flag,
  // control outputs
  output logic [can_front_pkg::DATA_W-1:0] control_byte,
  output logic soft_reset_active,
  // power
  output logic sleep_mode,
  output logic clkout_enable,
  output logic osc_run
);
  import can_front_pkg::*;

  // registers
  logic [DATA_W-1:0] ctl_ff;  // control byte
  logic sleep_req_ff;  // last written sleep request level
  logic pending_ff;  // send queued, not yet started
  logic busy_ff;  // frame on the bus
  logic done_ff;  // last requested send completed
  logic overrun_ff;  // data overrun status
  logic por_seen_ff;  // soft reset came from power-up
  logic bus_off_ff;  // shown bus-off flag
  logic err_ff;  // shown error warning flag
  logic wake_ff;  // wake interrupt flag
  logic wait_free_ff;  // woken by bus, wait for bus-free
  logic bus_off_d_ff;  // previous bus_off_in for edge detect
  logic [SLEEP_CNT_W-1:0] wind_cnt_ff;  // bit times since sleep entry
  logic [DATA_W-1:0] rdata_ff;
  pwr_state_t pwr_ff;

  // decoded strobes
  logic ctl_wr;
  logic cmd_wr;
  logic rr;
  logic cmd_send;
  logic cmd_abort;
  logic cmd_release;
  logic cmd_ovr_clear;
  logic overrun_set;
  logic rx_full;
  logic sleep_ok;
  logic [DATA_W-1:0] status_byte;

  assign ctl_wr = host_wr && (host_addr == ADDR_CONTROL);
  assign cmd_wr = host_wr && (host_addr == ADDR_COMMAND);
  assign rr = ctl_ff[CTL_SOFT_RST];

  // command bits only live for the write cycle, except the sleep bit, which is stored as a level
  assign cmd_send = cmd_wr && host_wdata[CMD_SEND] && !rr;
  assign cmd_abort = cmd_wr && host_wdata[CMD_ABORT] && !rr;
  // release is not masked by soft reset; the flush during soft reset empties the buffers
  assign cmd_release = cmd_wr && host_wdata[CMD_RX_RELEASE];
  assign cmd_ovr_clear = cmd_wr && host_wdata[CMD_OVR_CLEAR];

  // control byte: host read/write; soft reset drops test mode
  // bus-off raises reset request so the node leaves the bus at once
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctl_ff <= CTL_RESET_VAL;
    end else if (bus_off_in && !bus_off_d_ff) begin
      ctl_ff[CTL_SOFT_RST] <= 1'b1;
      ctl_ff[CTL_TEST_MODE] <= 1'b0;
    end else if (ctl_wr) begin
      ctl_ff <= host_wdata & CTL_WRITABLE;
      if (host_wdata[CTL_SOFT_RST]) begin
        ctl_ff[CTL_TEST_MODE] <= 1'b0;
      end
    end else if (rr) begin
      ctl_ff[CTL_TEST_MODE] <= 1'b0;
    end
  end

  // edge memory of bus-off input
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bus_off_d_ff <= 1'b0;
    end else begin
      bus_off_d_ff <= bus_off_in;
    end
  end

  // sleep request is a level: written one sleeps, written zero wakes
  always_ff @(posedge clk) begin
    if (sys_rst || rr) begin
      sleep_req_ff <= 1'b0;
    end else if (cmd_wr) begin
      sleep_req_ff <= host_wdata[CMD_SLEEP];
    end
  end

  // send queue: set by send, cleared by abort before start or by start
  // a zero in the send bit is no action, so the queue holds
  always_ff @(posedge clk) begin
    if (sys_rst || rr) begin
      pending_ff <= 1'b0;
    end else if (pending_ff && tx_start) begin
      pending_ff <= 1'b0;  // frame has begun; abort can no longer touch it
    end else if (cmd_abort) begin
      pending_ff <= 1'b0;
    end else if (cmd_send && !pending_ff && !busy_ff) begin
      pending_ff <= 1'b1;
    end
  end

  // frame in flight, ended by the engine or by soft reset
  always_ff @(posedge clk) begin
    if (sys_rst || rr) begin
      busy_ff <= 1'b0;
    end else if (pending_ff && tx_start) begin
      busy_ff <= 1'b1;
    end else if (!tx_active && !tx_start) begin
      busy_ff <= 1'b0;
    end
  end

  // completion flag: low from send until a good frame, aborted stays low
  always_ff @(posedge clk) begin
    if (sys_rst || rr) begin
      done_ff <= 1'b1;
    end else if (cmd_send && !pending_ff && !busy_ff) begin
      done_ff <= 1'b0;
    end else if (busy_ff && tx_done_ok) begin
      done_ff <= 1'b1;
    end
  end

  // overrun flag: detect wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst || rr) begin
      overrun_ff <= 1'b0;
    end else if (overrun_set) begin
      overrun_ff <= 1'b1;
    end else if (cmd_ovr_clear) begin
      overrun_ff <= 1'b0;
    end
  end

  // remember that the current soft reset began with a power-up reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      por_seen_ff <= 1'b1;
    end else if (!rr) begin
      por_seen_ff <= 1'b0;
    end
  end

  // bus-off and error flags follow the engine, forced clear only after power-up
  always_ff @(posedge clk) begin
    if (sys_rst || (rr && por_seen_ff)) begin
      bus_off_ff <= 1'b0;
      err_ff <= 1'b0;
    end else begin
      bus_off_ff <= bus_off_in;
      err_ff <= error_warn_in;
    end
  end

  // sleep allowed only with request, quiet bus and inactive interrupt
  assign sleep_ok = sleep_req_ff && !bus_activity && int_n;

  // power sequencer: wind down keeps the clock output for 15 bit times
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pwr_ff <= PWR_AWAKE;
      wind_cnt_ff <= '0;
    end else begin
      unique case (pwr_ff)
        PWR_AWAKE: begin
          wind_cnt_ff <= '0;
          if (sleep_ok) begin
            pwr_ff <= PWR_WIND_DOWN;
          end
        end
        PWR_WIND_DOWN: begin
          if (!sleep_ok) begin
            pwr_ff <= PWR_AWAKE;
          end else if (bit_tick) begin
            wind_cnt_ff <= wind_cnt_ff + SLEEP_CNT_W'(1);
            if (wind_cnt_ff == SLEEP_CNT_W'(SLEEP_CLKOUT_BITS - 1)) begin
              pwr_ff <= PWR_ASLEEP;
            end
          end
        end
        PWR_ASLEEP: begin
          if (!sleep_ok) begin
            pwr_ff <= PWR_AWAKE;
          end
        end
      endcase
    end
  end

  // wake interrupt flag: a wake beats a clear in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wake_ff <= 1'b0;
    end else if (pwr_ff != PWR_AWAKE && !sleep_ok) begin
      wake_ff <= 1'b1;
    end else if (wake_flag_clear) begin
      wake_ff <= 1'b0;
    end
  end

  // a bus wake lost the start of its frame; hold reception until bus-free
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wait_free_ff <= 1'b0;
    end else if (pwr_ff != PWR_AWAKE && bus_activity) begin
      wait_free_ff <= 1'b1;
    end else if (bus_free) begin
      wait_free_ff <= 1'b0;
    end
  end

  // receive buffer occupancy and overrun
  rx_buf_track u_rx_track (
    .clk(clk),
    .sys_rst(sys_rst),
    .store_first(rx_store_first && rx_enable),
    .store_done(rx_store_done && rx_enable),
    .release_pulse(cmd_release),
    .flush(rr),
    .full_flag(rx_full),
    .overrun_pulse(overrun_set),
    .drop_flag(rx_drop)
  );

  // status byte; soft reset shows idle, complete, free, empty
  always_comb begin
    status_byte = '0;
    status_byte[ST_BUS_OFF] = bus_off_ff;
    status_byte[ST_ERR_WARN] = err_ff;
    status_byte[ST_TX_ACT] = busy_ff && !rr;
    status_byte[ST_RX_ACT] = rx_active && !rr;
    status_byte[ST_SEND_DONE] = done_ff;
    status_byte[ST_TXBUF_FREE] = !(pending_ff || busy_ff);
    status_byte[ST_OVERRUN] = overrun_ff;
    status_byte[ST_RXBUF_FULL] = rx_full;
  end

  // registered read data; writes to status are ignored, command reads as ones
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_ff <= READ_NONE;
    end else if (host_rd) begin
      unique case (host_addr)
        ADDR_CONTROL: rdata_ff <= ctl_ff;
        ADDR_COMMAND: rdata_ff <= CMD_READ_VAL;
        ADDR_STATUS: rdata_ff <= status_byte;
        default: rdata_ff <= READ_NONE;
      endcase
    end
  end

  // outputs
  assign host_rdata = rdata_ff;
  assign control_byte = ctl_ff;
  assign soft_reset_active = rr;
  assign send_pending = pending_ff;
  assign abort_pulse = cmd_abort && pending_ff && !tx_start;
  assign rx_release = cmd_release;
  assign rx_enable = !wait_free_ff && !rr && pwr_ff == PWR_AWAKE;
  assign wake_irq_flag = wake_ff;
  assign sleep_mode = (pwr_ff != PWR_AWAKE);
  assign clkout_enable = (pwr_ff != PWR_ASLEEP);
  assign osc_run = (pwr_ff != PWR_ASLEEP);
endmodule

/* File: sim/can_ctrl_front_properties.sv */
/*
  can_ctrl_front_properties: port checks of the control, command and status front end.
  Assumes it is bound to every can_ctrl_front and sees only that module's ports.
*/
`timescale 1ns/1ps
module can_ctrl_front_checker (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // host port
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [can_front_pkg::ADDR_W-1:0] host_addr,
  input wire logic [can_front_pkg::DATA_W-1:0] host_wdata,
  input wire logic [can_front_pkg::DATA_W-1:0] host_rdata,
  // engines and power
  input wire logic tx_start,
  input wire logic tx_active,
  input wire logic send_pending,
  input wire logic abort_pulse,
  input wire logic rx_release,
  input wire logic rx_enable,
  input wire logic bus_off_in,
  input wire logic bus_activity,
  input wire logic bus_free,
  input wire logic int_n,
  input wire logic wake_irq_flag,
  input wire logic [can_front_pkg::DATA_W-1:0] control_byte,
  input wire logic sleep_mode,
  input wire logic clkout_enable,
  input wire logic osc_run
);
  import can_front_pkg::*;
  logic cmd_wr;  // write to the command byte
  logic run;  // soft reset released
  assign cmd_wr = host_wr && host_addr == ADDR_COMMAND;
  assign run = !control_byte[CTL_SOFT_RST];
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_cmd_ones;
    host_rd && host_addr == ADDR_COMMAND |=> host_rdata == CMD_READ_VAL;
  endproperty
  a_cmd_ones: assert property (p_cmd_ones) else $error("command byte read not all ones");
  // an idle engine must take a send at once
  property p_send_queues;
    cmd_wr && host_wdata[0] && !host_wdata[1] && run && !send_pending && !tx_active
      && !tx_start |=> send_pending;
  endproperty
  a_send_queues: assert property (p_send_queues) else $error("send not queued");
  // only abort, start or soft reset may drop a pending send
  property p_send_held;
    send_pending && run && !tx_start && !bus_off_in && !(cmd_wr && host_wdata[1])
      && !(host_wr && host_addr == ADDR_CONTROL) |=> send_pending;
  endproperty
  a_send_held: assert property (p_send_held) else $error("pending send withdrawn");
  property p_abort;
    send_pending && run && !tx_start && cmd_wr && host_wdata[1] |-> abort_pulse ##1 !send_pending;
  endproperty
  a_abort: assert property (p_abort) else $error("abort did not cancel send");
  property p_frame_kept;
    tx_start |-> !abort_pulse;
  endproperty
  a_frame_kept: assert property (p_frame_kept) else $error("started frame aborted");
  property p_release;
    cmd_wr && host_wdata[CMD_RX_RELEASE] && run |-> rx_release;
  endproperty
  a_release: assert property (p_release) else $error("release not passed on");
  property p_reset_clears;
    control_byte[CTL_SOFT_RST] && $past(control_byte[CTL_SOFT_RST]) |-> !send_pending && !rx_enable;
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("soft reset left state");
  property p_sleep_entry;
    $rose(sleep_mode) |-> $past(int_n) && !$past(bus_activity);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entered wrongly");
  property p_clk_awake;
    !sleep_mode |-> clkout_enable && osc_run;
  endproperty
  a_clk_awake: assert property (p_clk_awake) else $error("clock stopped while awake");
  // bus wake: awake next edge, flag up, reception held off
  property p_bus_wake;
    sleep_mode && bus_activity && !bus_free |=> !sleep_mode && wake_irq_flag && !rx_enable;
  endproperty
  a_bus_wake: assert property (p_bus_wake) else $error("bus wake wrong");
  c_start: cover property (tx_start);
  c_abort: cover property (abort_pulse);
  c_sleep: cover property ($rose(sleep_mode));
  c_wake: cover property ($rose(wake_irq_flag));
endmodule
bind can_ctrl_front can_ctrl_front_checker can_ctrl_front_checker_inst (.clk, .sys_rst,
  .host_wr, .host_rd, .host_addr, .host_wdata, .host_rdata, .tx_start, .tx_active,
  .send_pending, .abort_pulse, .rx_release, .rx_enable, .bus_off_in, .bus_activity,
  .bus_free, .int_n, .wake_irq_flag, .control_byte, .sleep_mode, .clkout_enable, .osc_run);

/* File: sim/host_model.sv */
/*
  host_model: byte-wide host that reads and writes the front end.
  Assumes strobes are sampled on the rising edge; it drives at falling edges.
*/
`timescale 1ns/1ps
module host_model (
  // clock
  input wire logic clk,
  // host port
  output logic host_wr,
  output logic host_rd,
  output logic [can_front_pkg::ADDR_W-1:0] host_addr,
  output logic [can_front_pkg::DATA_W-1:0] host_wdata,
  input wire logic [can_front_pkg::DATA_W-1:0] host_rdata
);
  import can_front_pkg::*;
  // idle bus from time zero
  initial begin
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_addr = 5'h1F;
    host_wdata = 8'h00;
  end
  // one-cycle write strobe; released data shows its inverse, not a stale value
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk);
    host_addr = a;
    host_wdata = d;
    host_wr = 1'b1;
    @(negedge clk);
    host_wr = 1'b0;
    host_wdata = ~d;
  endtask
  // one-cycle read strobe; data is registered, so taken a cycle later
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(negedge clk);
    host_addr = a;
    host_rd = 1'b1;
    @(negedge clk);
    host_rd = 1'b0;
    d = host_rdata;
  endtask
endmodule

/* File: sim/testbench.sv */
/*
  testbench: runs can_ctrl_front through the host model and engine pins.
  Assumes the 200 MHz clock and a synchronous power-up reset.
*/
`timescale 1ns/1ps
module testbench;
  import can_front_pkg::*;
  logic clk, sys_rst, host_wr, host_rd, tx_start, tx_done_ok, tx_active, rx_active;
  logic rx_store_first, rx_store_done, bus_off_in, error_warn_in, bus_activity, bus_free;
  logic bit_tick, int_n, wake_flag_clear, send_pending, abort_pulse, rx_enable, rx_drop;
  logic rx_release, wake_irq_flag, soft_reset_active, sleep_mode, clkout_enable, osc_run;
  logic [ADDR_W-1:0] host_addr;
  logic [DATA_W-1:0] host_wdata, host_rdata, control_byte, rd_data;
  int n_mismatch, compares, cycles;
  can_ctrl_front can_ctrl_front_inst (.clk, .sys_rst, .host_wr, .host_rd, .host_addr,
    .host_wdata, .host_rdata, .tx_start, .tx_done_ok, .tx_active, .send_pending,
    .abort_pulse, .rx_active, .rx_store_first, .rx_store_done, .rx_enable, .rx_drop,
    .rx_release, .bus_off_in, .error_warn_in, .bus_activity, .bus_free, .bit_tick, .int_n,
    .wake_flag_clear, .wake_irq_flag, .control_byte, .soft_reset_active, .sleep_mode,
    .clkout_enable, .osc_run);
  host_model host_model_inst (.clk, .host_wr, .host_rd, .host_addr, .host_wdata, .host_rdata);
  // clock, 5 ns period
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // cut a hang short; the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      close_out();
    end
  end
  task automatic close_out();
    if (n_mismatch == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [4:0] a, input logic [7:0] exp);
    host_model_inst.rd(a, rd_data);
    chk(rd_data, exp);
  endtask
  // one received message, first byte then completion
  task automatic msg();
    @(negedge clk);
    rx_active = 1'b1;
    rx_store_first = 1'b1;
    @(negedge clk);
    rx_store_first = 1'b0;
    rx_store_done = 1'b1;
    @(negedge clk);
    rx_store_done = 1'b0;
    rx_active = 1'b0;
  endtask
  initial begin
    {tx_start, tx_done_ok, tx_active, rx_active, rx_store_first, rx_store_done} = '0;
    {bus_activity, bus_free, bit_tick, wake_flag_clear} = '0;
    {bus_off_in, error_warn_in, int_n, sys_rst} = 4'hF;
    n_mismatch = 0;
    compares = 0;
    cycles = 0;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    // power-up values; bus-off and warning masked after power-up
    rdc(ADDR_CONTROL, 8'h01);
    rdc(ADDR_STATUS, 8'h0C);
    rdc(ADDR_COMMAND, 8'hFF);
    rdc(5'h05, 8'h00);
    {bus_off_in, error_warn_in} = 2'b00;
    host_model_inst.wr(ADDR_CONTROL, 8'hFE);
    rdc(ADDR_CONTROL, 8'hDE);
    host_model_inst.wr(ADDR_CONTROL, 8'h00);
    host_model_inst.wr(ADDR_STATUS, 8'hFF);
    rdc(ADDR_STATUS, 8'h0C);
    // send, then a frame that a late abort must not stop
    host_model_inst.wr(ADDR_COMMAND, 8'h01);
    rdc(ADDR_STATUS, 8'h00);
    host_model_inst.wr(ADDR_COMMAND, 8'h00);
    chk(send_pending, 8'h01);
    tx_start = 1'b1;
    tx_active = 1'b1;
    @(negedge clk);
    tx_start = 1'b0;
    host_model_inst.wr(ADDR_COMMAND, 8'h02);
    rdc(ADDR_STATUS, 8'h20);
    tx_done_ok = 1'b1;
    @(negedge clk);
    tx_done_ok = 1'b0;
    tx_active = 1'b0;
    rdc(ADDR_STATUS, 8'h0C);
    // abort before start: buffer freed, completion stays low
    host_model_inst.wr(ADDR_COMMAND, 8'h01);
    host_model_inst.wr(ADDR_COMMAND, 8'h02);
    rdc(ADDR_STATUS, 8'h04);
    // receive, release, overrun with a dropped third message
    msg();
    rdc(ADDR_STATUS, 8'h05);
    host_model_inst.wr(ADDR_COMMAND, 8'h04);
    rdc(ADDR_STATUS, 8'h04);
    repeat (3) msg();
    rdc(ADDR_STATUS, 8'h07);
    chk(rx_drop, 8'h00);
    host_model_inst.wr(ADDR_COMMAND, 8'h08);
    rdc(ADDR_STATUS, 8'h05);
    repeat (2) host_model_inst.wr(ADDR_COMMAND, 8'h04);
    rdc(ADDR_STATUS, 8'h04);
    // sleep held off by a low interrupt pin
    int_n = 1'b0;
    host_model_inst.wr(ADDR_COMMAND, 8'h10);
    @(negedge clk);
    chk(sleep_mode, 8'h00);
    int_n = 1'b1;
    repeat (2) @(negedge clk);
    chk(sleep_mode, 8'h01);
    for (int i = 0; i < 15; i++) begin
      chk(clkout_enable, 8'h01);
      bit_tick = 1'b1;
      @(negedge clk);
      bit_tick = 1'b0;
      @(negedge clk);
    end
    @(negedge clk);
    chk({clkout_enable, osc_run}, 8'h00);
    bus_activity = 1'b1;
    @(negedge clk);
    chk({sleep_mode, wake_irq_flag, osc_run, rx_enable}, 8'h06);
    bus_free = 1'b1;
    wake_flag_clear = 1'b1;
    @(negedge clk);
    {bus_free, wake_flag_clear, bus_activity} = 3'b000;
    chk({rx_enable, wake_irq_flag}, 8'h02);
    repeat (2) @(negedge clk);
    chk(sleep_mode, 8'h01);
    host_model_inst.wr(ADDR_COMMAND, 8'h00);
    @(negedge clk);
    chk({sleep_mode, osc_run}, 8'h01);
    // soft reset later: send dropped, test mode cleared, bus-off shown
    host_model_inst.wr(ADDR_COMMAND, 8'h01);
    host_model_inst.wr(ADDR_CONTROL, 8'h81);
    rdc(ADDR_CONTROL, 8'h01);
    chk({send_pending, rx_enable}, 8'h00);
    chk({soft_reset_active, control_byte}, 9'h101);
    {bus_off_in, error_warn_in} = 2'b11;
    rdc(ADDR_STATUS, 8'hCC);
    close_out();
  end
endmodule
